// ===== shared/edpsm_regs.svh
/*
 register offsets, byte lane positions and reset values of the port.
 assumes a byte-addressed 32-bit avalon-mm slave with one word per register.
*/
`ifndef EDPSM_REGS_SVH
`define EDPSM_REGS_SVH

// byte offsets of the word registers
`define EDPSM_OFF_LEVEL 4'h0
`define EDPSM_OFF_DIR 4'h4
`define EDPSM_OFF_LAT 4'h8
`define EDPSM_OFF_DRIVE 4'hc

// low data byte and its byte enable
`define EDPSM_LANE0 7:0
`define EDPSM_BE_LO 0

// reset values
`define EDPSM_DIR_RST 8'hff
`define EDPSM_LAT_RST 8'h00
`define EDPSM_BYTE_RST 8'h00
`define EDPSM_WORD_RST 32'h0000_0000

`endif

// ===== shared/edpsm_pkg.sv
/*
 types shared by the port controller, its pin multiplexer and the carrier.
 assumes nothing of its surroundings.
*/
`default_nettype none

package edpsm_pkg;
   // data widths of the port and of the bus
   typedef logic [7:0] edpsm_byte_t;
   typedef logic [31:0] edpsm_word_t;
   typedef logic [3:0] edpsm_addr_t;
   // register selected by a bus address
   typedef enum logic [2:0] {
      EDPSM_REG_NONE,
      EDPSM_REG_LEVEL,
      EDPSM_REG_DIR,
      EDPSM_REG_LAT,
      EDPSM_REG_DRIVE
   } edpsm_reg_t;
   // bus answer sequencer
   typedef enum logic {
      EDPSM_BUS_IDLE,
      EDPSM_BUS_ACK
   } edpsm_bus_st_t;
endpackage

`default_nettype wire

// ===== shared/edpsm_pin_if.sv
/*
 carrier between the register side and the pin multiplexer.
 assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface edpsm_pin_if;
   import edpsm_pkg::*;
   // register side to pins
   edpsm_byte_t lat;
   edpsm_byte_t dir;
   edpsm_byte_t seg;
   // pins to register side
   edpsm_byte_t level;
   edpsm_byte_t drive;
   modport ctrl (output lat, output dir, output seg, input level, input drive);
   modport mux (input lat, input dir, input seg, output level, output drive);
endinterface

`default_nettype wire

// ===== logic/edpsm_pinmux.sv
/*
 per-pin output drive, direction and segment takeover, plus input sync.
 assumes raw pad levels from outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "edpsm_regs.svh"

module edpsm_pinmux (
   input wire logic clk,
   input wire logic sys_rst,
   edpsm_pin_if.mux pif,
   input wire edpsm_pkg::edpsm_byte_t pad_in,
   output var edpsm_pkg::edpsm_byte_t pad_out,
   output var edpsm_pkg::edpsm_byte_t pad_oe,
   output var edpsm_pkg::edpsm_byte_t lcd_segment_sel
);
   import edpsm_pkg::*;

   edpsm_byte_t sync1_r, sync2_r;
   edpsm_byte_t out_r, oe_r, segsel_r;
   edpsm_byte_t out_nxt, oe_nxt;

   // per pin: segment kills the digital path, direction only when free
   genvar i;
   generate
      for (i = 0; i < $bits(edpsm_byte_t); i++) begin : g_pin
         assign oe_nxt[i] = ~pif.seg[i] & ~pif.dir[i];
         assign out_nxt[i] = pif.lat[i] & oe_nxt[i];
      end
   endgenerate

   // two-stage synchroniser on the pad levels
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_r <= `EDPSM_BYTE_RST;
         sync2_r <= `EDPSM_BYTE_RST;
      end else begin
         sync1_r <= pad_in;
         sync2_r <= sync1_r;
      end
   end

   // registered pad drive; all drivers off under reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_r <= `EDPSM_BYTE_RST;
         oe_r <= `EDPSM_BYTE_RST;
         segsel_r <= `EDPSM_BYTE_RST;
      end else begin
         out_r <= out_nxt;
         oe_r <= oe_nxt;
         segsel_r <= pif.seg;
      end
   end

   // segment pins read as zero, port input is unavailable there
   assign pif.level = sync2_r & ~pif.seg;
   assign pif.drive = oe_r;
   assign pad_out = out_r;
   assign pad_oe = oe_r;
   assign lcd_segment_sel = segsel_r;
endmodule

`default_nettype wire

// ===== logic/edpsm_port.sv
/*
 eight-pin port with lcd segment sharing: avalon-mm slave holding the
 pin level, direction, output latch and drive status registers.
 assumes seg_enable_low comes from the lcd controller on clk and the
 pads arrive raw from outside; pad wires are resolved outside.
*/
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "edpsm_regs.svh"

// Operation
// - eight pins, each latch, direction, input bit
// - direction one puts driver in high impedance
// - direction zero drives latch bit on pin
// - latch register reads back latch, not pins
// - direction set independently for every pin
// - after reset all pins are inputs
// - port functions only while segment disabled
// - enabled segment suppresses digital output
// - direction bit ignored on segment pins
// - pin n carries lcd segment n
module edpsm_port (
   input wire logic clk,
   input wire logic sys_rst,
   input wire edpsm_pkg::edpsm_addr_t avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire edpsm_pkg::edpsm_word_t avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output var edpsm_pkg::edpsm_word_t avs_readdata,
   output var logic avs_waitrequest,
   input wire edpsm_pkg::edpsm_byte_t seg_enable_low,
   input wire edpsm_pkg::edpsm_byte_t pad_in,
   output var edpsm_pkg::edpsm_byte_t pad_out,
   output var edpsm_pkg::edpsm_byte_t pad_oe,
   output var edpsm_pkg::edpsm_byte_t lcd_segment_sel
);
   import edpsm_pkg::*;

   // map a byte address onto a register
   function automatic edpsm_reg_t reg_sel(input edpsm_addr_t a);
      reg_sel = EDPSM_REG_NONE;
      if (a == `EDPSM_OFF_LEVEL) begin
         reg_sel = EDPSM_REG_LEVEL;
      end else if (a == `EDPSM_OFF_DIR) begin
         reg_sel = EDPSM_REG_DIR;
      end else if (a == `EDPSM_OFF_LAT) begin
         reg_sel = EDPSM_REG_LAT;
      end else if (a == `EDPSM_OFF_DRIVE) begin
         reg_sel = EDPSM_REG_DRIVE;
      end
   endfunction

   edpsm_bus_st_t bus_st_r, bus_st_nxt;
   edpsm_byte_t lat_r, lat_nxt;
   edpsm_byte_t dir_r, dir_nxt;
   edpsm_word_t rdata_r, rdata_nxt;
   edpsm_byte_t rd_byte;
   edpsm_reg_t sel;
   logic req;
   logic acc;
   logic rd_take;
   logic lo_lane;
   logic lat_wr;
   logic dir_wr;

   edpsm_pin_if pin_if ();

   // pin multiplexer: drive, direction, segment takeover, input sync
   edpsm_pinmux u_pinmux (
      .clk(clk),
      .sys_rst(sys_rst),
      .pif(pin_if.mux),
      .pad_in(pad_in),
      .pad_out(pad_out),
      .pad_oe(pad_oe),
      .lcd_segment_sel(lcd_segment_sel)
   );

   // register values and segment enables towards the pins
   assign pin_if.lat = lat_r;
   assign pin_if.dir = dir_r;
   assign pin_if.seg = seg_enable_low;

   // request decode
   assign req = avs_read | avs_write;
   assign sel = reg_sel(avs_address);
   assign acc = req & (bus_st_r == EDPSM_BUS_ACK);
   assign rd_take = avs_read & (bus_st_r == EDPSM_BUS_IDLE);
   assign lo_lane = avs_byteenable[`EDPSM_BE_LO];

   // one wait cycle per access, answer in the second cycle
   assign avs_waitrequest = req & (bus_st_r == EDPSM_BUS_IDLE);

   // answer sequencer
   always_comb begin
      bus_st_nxt = bus_st_r;
      unique case (bus_st_r)
         EDPSM_BUS_IDLE: begin
            if (req) begin
               bus_st_nxt = EDPSM_BUS_ACK;
            end
         end
         EDPSM_BUS_ACK: begin
            bus_st_nxt = EDPSM_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_st_r <= EDPSM_BUS_IDLE;
      end else begin
         bus_st_r <= bus_st_nxt;
      end
   end

   // latch is written through either the level or the latch address
   assign lat_wr = acc & avs_write & lo_lane &
      ((sel == EDPSM_REG_LAT) | (sel == EDPSM_REG_LEVEL));
   assign dir_wr = acc & avs_write & lo_lane & (sel == EDPSM_REG_DIR);
   assign lat_nxt = lat_wr ? avs_writedata[`EDPSM_LANE0] : lat_r;
   assign dir_nxt = dir_wr ? avs_writedata[`EDPSM_LANE0] : dir_r;

   // latch and direction registers; direction powers up as inputs
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lat_r <= `EDPSM_LAT_RST;
         dir_r <= `EDPSM_DIR_RST;
      end else begin
         lat_r <= lat_nxt;
         dir_r <= dir_nxt;
      end
   end

   // read mux; level shows pins, latch shows latch, unmapped is zero
   assign rd_byte = (sel == EDPSM_REG_LEVEL) ? pin_if.level :
      (sel == EDPSM_REG_DIR) ? dir_r :
      (sel == EDPSM_REG_LAT) ? lat_r :
      (sel == EDPSM_REG_DRIVE) ? pin_if.drive :
      `EDPSM_BYTE_RST;
   assign rdata_nxt = rd_take ? edpsm_word_t'(rd_byte) : rdata_r;

   // read data captured in the wait cycle, held through the answer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= `EDPSM_WORD_RST;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign avs_readdata = rdata_r;

   // assertions on the pin path and the register file
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // inputs never drive
   AST_DIR_HIZ:
      assert property (1'b1 |=> ((pad_oe & $past(dir_r)) == '0))
      else $error("pin driven while its direction is input");

   // output pins show the latch
   AST_DRIVE_LAT:
      assert property (1'b1 |=> (((pad_out ^ $past(lat_r)) & pad_oe) == '0))
      else $error("driven pin differs from latch");

   // free output pins are really driven
   AST_OUT_ON:
      assert property (1'b1 |=> (pad_oe == ~($past(dir_r) | $past(seg_enable_low))))
      else $error("drive enable does not follow direction");

   // latch read returns the latch, not the pins
   property p_lat_read;
      (rd_take && sel == EDPSM_REG_LAT) |=>
         (avs_readdata == edpsm_word_t'($past(lat_r))) && !avs_waitrequest;
   endproperty
   AST_LAT_RB:
      assert property (p_lat_read)
      else $error("latch read returned wrong value");

   // drivers stay off throughout reset
   AST_RST_HIZ:
      assert property (@(posedge clk) disable iff (1'b0)
         sys_rst |-> (pad_oe == '0 && dir_r == `EDPSM_DIR_RST))
      else $error("driver on or direction wrong during reset");

   // segment pins read as zero on the level register
   AST_SEG_NO_IN:
      assert property ((rd_take && sel == EDPSM_REG_LEVEL) |=>
         ((avs_readdata[`EDPSM_LANE0] & $past(seg_enable_low)) == '0))
      else $error("segment pin visible as port input");

   // segment enable suppresses digital drive
   AST_SEG_KILL:
      assert property (1'b1 |=> ((pad_oe & $past(seg_enable_low)) == '0))
      else $error("segment pin still driven digitally");

   // direction bit has no effect on a segment pin, even across writes
   AST_SEG_DIR:
      assert property ((seg_enable_low != '0 && dir_wr) |=>
         ((pad_oe & lcd_segment_sel) == '0) [*2])
      else $error("direction overrides segment pin");

   // pin n follows segment n one cycle later
   AST_SEG_MAP:
      assert property (1'b1 |=> (lcd_segment_sel == $past(seg_enable_low)))
      else $error("segment select not mapped to its own pin");

   // level write updates the latch
   AST_LEVEL_WR:
      assert property ((acc && avs_write && lo_lane && sel == EDPSM_REG_LEVEL)
         |=> (lat_r == $past(avs_writedata[`EDPSM_LANE0])))
      else $error("level write did not reach latch");

   // level read shows pins through the synchroniser
   AST_PIN_PATH:
      assert property ((rd_take && sel == EDPSM_REG_LEVEL && seg_enable_low == '0)
         |=> (avs_readdata[`EDPSM_LANE0] == $past(pad_in, 3)))
      else $error("level read does not match pins");

   // direction write is read back as written, by the next access
   AST_DIR_RB:
      assert property ((dir_wr ##2 (rd_take && sel == EDPSM_REG_DIR)) |=>
         (avs_readdata[`EDPSM_LANE0] == $past(avs_writedata[`EDPSM_LANE0], 3)))
      else $error("direction readback wrong");

   // drive status read shows the live drive enables
   AST_DRIVE_RB:
      assert property ((rd_take && sel == EDPSM_REG_DRIVE) |=>
         (avs_readdata == edpsm_word_t'($past(pad_oe))))
      else $error("drive status read differs from drive enables");

   // a write without its low byte enable leaves latch and direction alone
   AST_NO_LANE:
      assert property ((acc && avs_write && !lo_lane) |=>
         (lat_r == $past(lat_r) && dir_r == $past(dir_r)))
      else $error("write without byte enable changed a register");

   // only the low byte of read data ever carries a value
   AST_RD_HIGH:
      assert property ((avs_readdata >> $bits(edpsm_byte_t)) == '0)
      else $error("read data upper bytes not zero");

   // every request is answered in the following cycle
   AST_WAIT:
      assert property ((req && bus_st_r == EDPSM_BUS_IDLE) |=>
         (!avs_waitrequest || !req))
      else $error("request not answered after one wait cycle");

   // unmapped reads return zero
   AST_UNMAPPED:
      assert property ((rd_take && sel == EDPSM_REG_NONE) |=>
         (avs_readdata == `EDPSM_WORD_RST))
      else $error("unmapped read not zero");

   // main scenarios
   COV_LAT_READ: cover property (rd_take && sel == EDPSM_REG_LAT ##1 acc);
   COV_DIR_OUT: cover property (dir_wr ##2 pad_oe != '0);
   COV_SEG_TAKE: cover property (pad_oe != '0 ##1 seg_enable_low != '0 ##1
      (pad_oe & lcd_segment_sel) == '0);
   COV_LEVEL_WR: cover property (acc && avs_write && sel == EDPSM_REG_LEVEL);
   COV_DIR_RB: cover property (dir_wr ##2 (rd_take && sel == EDPSM_REG_DIR));
endmodule

`default_nettype wire

// ===== sim/edpsm_pad_model.sv
/*
 board side of the port pins: a board source on undriven pins and
 the lcd segment driver on enabled ones.
 assumes the board source never fights a pad that the port drives.
*/
`timescale 1ns/1ps
`default_nettype none

module edpsm_pad_model (
   input wire edpsm_pkg::edpsm_byte_t pad_out,
   input wire edpsm_pkg::edpsm_byte_t pad_oe,
   input wire edpsm_pkg::edpsm_byte_t lcd_segment_sel,
   input wire edpsm_pkg::edpsm_byte_t ext_level,
   output var edpsm_pkg::edpsm_byte_t pad_in
);
   import edpsm_pkg::*;
   edpsm_byte_t seg_wave;
   // segment waveform stand-in, unlike the board level
   assign seg_wave = ~ext_level;
   // per-pin level: segment first, then port driver, then board
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         if (lcd_segment_sel[n]) begin
            pad_in[n] = seg_wave[n];
         end else if (pad_oe[n]) begin
            pad_in[n] = pad_out[n];
         end else begin
            pad_in[n] = ext_level[n];
         end
      end
   end
endmodule

`default_nettype wire

// ===== sim/test_eight_bit_port_with_segment_mux.sv
/*
 self-checking bench of the port: avalon-mm tasks and pin scenarios.
 assumes the pad model resolves the pin levels.
*/
`timescale 1ns/1ps
`default_nettype none
`include "edpsm_regs.svh"

module test_eight_bit_port_with_segment_mux;
   import edpsm_pkg::*;
   logic clk;
   logic sys_rst;
   edpsm_addr_t avs_address;
   logic avs_read;
   logic avs_write;
   edpsm_word_t avs_writedata;
   logic [3:0] avs_byteenable;
   edpsm_word_t avs_readdata;
   logic avs_waitrequest;
   edpsm_byte_t seg_enable_low;
   edpsm_byte_t pad_in;
   edpsm_byte_t pad_out;
   edpsm_byte_t pad_oe;
   edpsm_byte_t lcd_segment_sel;
   edpsm_byte_t ext_level;
   edpsm_word_t rd;
   int err_count;
   int total_checks;

   edpsm_port uut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .seg_enable_low(seg_enable_low),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .lcd_segment_sel(lcd_segment_sel));

   edpsm_pad_model pads (.pad_out(pad_out), .pad_oe(pad_oe),
      .lcd_segment_sel(lcd_segment_sel), .ext_level(ext_level), .pad_in(pad_in));

   // 200 mhz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // verdict, then end of run
   task automatic report_and_stop();
      if (err_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // one comparison
   task automatic chk(input edpsm_word_t got, input edpsm_word_t exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one bus access, held until waitrequest is seen low
   task automatic bus(input logic wr, input edpsm_addr_t addr, input edpsm_byte_t data,
         input logic be, output edpsm_word_t q);
      int n;
      @(posedge clk);
      avs_address <= addr;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= {24'hab_cdef, data};
      avs_byteenable <= {3'h7, be};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0) begin
         err_count++;
         report_and_stop();
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input edpsm_addr_t addr, input edpsm_byte_t data);
      bus(1'b1, addr, data, 1'b1, rd);
   endtask

   task automatic rdchk(input edpsm_addr_t addr, input edpsm_byte_t exp);
      bus(1'b0, addr, 8'h00, 1'b1, rd);
      chk(rd, {24'h00_0000, exp});
   endtask

   // pins and synchroniser settle
   task automatic settle();
      repeat (4) @(posedge clk);
   endtask

   // main sequence
   initial begin
      sys_rst = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'h0;
      seg_enable_low = 8'h00;
      ext_level = 8'h3c;
      err_count = 0;
      total_checks = 0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      // power-up state
      rdchk(`EDPSM_OFF_DIR, 8'hff);
      rdchk(`EDPSM_OFF_LAT, 8'h00);
      chk({24'h00_0000, pad_oe}, 32'h0000_0000);
      rdchk(`EDPSM_OFF_LEVEL, 8'h3c);
      // mixed directions
      wr(`EDPSM_OFF_LAT, 8'ha5);
      wr(`EDPSM_OFF_DIR, 8'h0f);
      rdchk(`EDPSM_OFF_DIR, 8'h0f);
      settle();
      chk({24'h00_0000, pad_oe}, 32'h0000_00f0);
      chk({24'h00_0000, pad_out}, 32'h0000_00a0);
      rdchk(`EDPSM_OFF_LAT, 8'ha5);
      rdchk(`EDPSM_OFF_LEVEL, 8'hac);
      rdchk(`EDPSM_OFF_DRIVE, 8'hf0);
      // level write lands in latch; refused writes change nothing
      wr(`EDPSM_OFF_LEVEL, 8'h5a);
      rdchk(`EDPSM_OFF_LAT, 8'h5a);
      bus(1'b1, `EDPSM_OFF_LAT, 8'hff, 1'b0, rd);
      wr(`EDPSM_OFF_DRIVE, 8'h00);
      wr(4'h2, 8'h33);
      rdchk(`EDPSM_OFF_LAT, 8'h5a);
      rdchk(`EDPSM_OFF_DRIVE, 8'hf0);
      rdchk(4'h2, 8'h00);
      // segments take over pins 0 and 7
      wr(`EDPSM_OFF_LAT, 8'hff);
      seg_enable_low <= 8'h81;
      wr(`EDPSM_OFF_DIR, 8'h00);
      settle();
      chk({24'h00_0000, lcd_segment_sel}, 32'h0000_0081);
      chk({24'h00_0000, pad_oe}, 32'h0000_007e);
      chk({24'h00_0000, pad_out}, 32'h0000_007e);
      rdchk(`EDPSM_OFF_LEVEL, 8'h7e);
      // segments released give the pins back
      seg_enable_low <= 8'h00;
      settle();
      chk({24'h00_0000, pad_oe}, 32'h0000_00ff);
      // reset in mid-run
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      chk({24'h00_0000, pad_oe}, 32'h0000_0000);
      rdchk(`EDPSM_OFF_DIR, 8'hff);
      report_and_stop();
   end
endmodule

`default_nettype wire
